// *** hw/cec_tx_defines.vh ***
`ifndef CEC_TX_DEFINES_VH
`define CEC_TX_DEFINES_VH

// register addresses, one word each
`define ADDR_TX_ENABLE_CTRL    8'h00
`define ADDR_TX_BYTE_BUFFER    8'h04
`define ADDR_TX_TIMING_CONTROL 8'h08
`define ADDR_TX_IRQ_STATUS     8'h0C
`define ADDR_TX_IRQ_MASK       8'h10

// tx_enable_ctrl fields
`define BIT_TX_ENABLE      0
`define BIT_TX_IN_PROGRESS 1

// tx_byte_buffer fields
`define BIT_TX_EOM 8

// tx_timing_control fields
`define FLD_START_RISE_HI  22
`define FLD_START_RISE_LO  20
`define FLD_START_PRD_HI   18
`define FLD_START_PRD_LO   16
`define FLD_DATA_RISE_HI   14
`define FLD_DATA_RISE_LO   12
`define FLD_DATA_PRD_HI    11
`define FLD_DATA_PRD_LO    8
`define BIT_BROADCAST      4
`define FLD_BUS_FREE_HI    3
`define FLD_BUS_FREE_LO    0
`define TIMING_WRITE_MASK  32'h00777F1F

// interrupt status / mask bits
`define BIT_IRQ_DONE  0
`define BIT_IRQ_ERROR 1
`define IRQ_WIDTH     2

// bit timing base values in fs periods
`define START_RISE_BASE 8'd121
`define START_PRD_BASE  8'd147
`define DATA1_RISE_BASE 8'd20
`define DATA0_RISE_BASE 8'd49
`define DATA_PRD_BASE   8'd79

// fs sampling clock period in ns, and core clock period in ns
`define FS_PERIOD_NS    30518
`define CORE_PERIOD_NS  10

`endif

// *** hw/cec_transmit_control.v ***
// Behaviour
// - busy flag rises at start bit, falls on finish or any interrupt
// - busy flag is read only; writes leave it unchanged; here a write of zero to enable clears it with the abort
// - writing one to enable starts sending the buffered byte
// - enable is write only; zero disables, one enables
// - enable clears itself on completion or error interrupt
// - end-of-message bit comes from byte register bit 8
// - data byte is bits 7..0, sent most significant bit first
// - start rise at 121 fs periods minus 3-bit field
// - start period 147 fs periods minus 3-bit field
// - data rise 20 or 49 periods minus 0..3; codes 4..7 reserved
// - data period 79 fs periods minus 4-bit field
// - line must stay idle for field plus one bit periods first
//
// Chosen here: the plain strobed port and the register addresses.
`include "cec_tx_defines.vh"
`timescale 1ns/1ns
`default_nettype none

module cec_transmit_control #(
	parameter FS_DIV = (`FS_PERIOD_NS + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS
) (
	// clock and reset
	input  wire        core_clk_in,
	input  wire        reset_in,
	// register port
	input  wire [7:0]  addr_in,
	input  wire [31:0] wdata_in,
	input  wire        wr_in,
	input  wire        rd_in,
	output reg  [31:0] rdata_out,
	// cec line, open drain
	input  wire        cec_in,
	output wire        cec_out,
	output wire        cec_oe_out,
	// interrupt
	output wire        irq_out
);

	localparam ST_IDLE  = 3'd0;
	localparam ST_FREE  = 3'd1;
	localparam ST_START = 3'd2;
	localparam ST_DATA  = 3'd3;
	localparam ST_ACK   = 3'd4;
	localparam [3:0] EOM_IDX = 4'd8;

	reg        tx_enable_q;
	reg        tx_in_progress_q;
	reg [8:0]  tx_byte_q;
	reg [31:0] timing_q;
	reg [`IRQ_WIDTH-1:0] irq_status_q;
	reg [`IRQ_WIDTH-1:0] irq_mask_q;
	reg [2:0]  state_q;
	reg [15:0] fs_div_q;
	reg [7:0]  tick_cnt_q;
	reg [3:0]  bit_idx_q;
	reg [4:0]  free_cnt_q;
	reg        line_low_q;
	reg        cec_sync1_q;
	reg        cec_sync2_q;

	wire fs_tick = (fs_div_q == FS_DIV[15:0] - 16'd1);

	wire [2:0] start_rise_adj = timing_q[`FLD_START_RISE_HI:`FLD_START_RISE_LO];
	wire [2:0] start_prd_adj  = timing_q[`FLD_START_PRD_HI:`FLD_START_PRD_LO];
	wire [2:0] data_rise_adj  = timing_q[`FLD_DATA_RISE_HI:`FLD_DATA_RISE_LO];
	wire [3:0] data_prd_adj   = timing_q[`FLD_DATA_PRD_HI:`FLD_DATA_PRD_LO];
	wire [3:0] bus_free_cycles = timing_q[`FLD_BUS_FREE_HI:`FLD_BUS_FREE_LO];
	wire       broadcast_select = timing_q[`BIT_BROADCAST];

	// the bit currently on the wire: 8 data bits, eom, then ack slot
	function cur_bit;
		input [8:0] byte_word;
		input [3:0] idx;
		begin
			if (idx < 4'd8)
				cur_bit = byte_word[4'd7 - idx];
			else if (idx == EOM_IDX)
				cur_bit = byte_word[`BIT_TX_EOM];
			else
				cur_bit = 1'b1;
		end
	endfunction

	function [7:0] sub_adj;
		input [7:0] base;
		input [3:0] adj;
		begin
			sub_adj = base - {4'h0, adj};
		end
	endfunction

	// true on the fs tick that closes a phase of the given length
	function tick_at;
		input       tick;
		input [7:0] cnt;
		input [7:0] len;
		begin
			tick_at = tick && (cnt == len - 8'd1);
		end
	endfunction

	// one decode for every register select, so strobe and address stay paired
	function reg_hit;
		input       strobe;
		input [7:0] addr;
		input [7:0] offset;
		begin
			reg_hit = strobe && (addr == offset);
		end
	endfunction

	// rise time follows the bit on the wire; the ack slot rises as a one
	wire       bit_val = cur_bit(tx_byte_q, bit_idx_q);
	// reserved rise codes use only the low two bits, so they act as 0..3
	wire [7:0] data_rise = sub_adj(bit_val ? `DATA1_RISE_BASE : `DATA0_RISE_BASE,
	                               {2'b00, data_rise_adj[1:0]});
	wire [7:0] data_prd   = sub_adj(`DATA_PRD_BASE, data_prd_adj);
	wire [7:0] start_rise = sub_adj(`START_RISE_BASE, {1'b0, start_rise_adj});
	wire [7:0] start_prd  = sub_adj(`START_PRD_BASE, {1'b0, start_prd_adj});

	// ack slot: the device releases and samples; a broadcast expects a one,
	// a directed message expects a zero from the follower
	wire ack_bad = broadcast_select ? ~cec_sync2_q : cec_sync2_q;

	// one select per register; only the enable register reacts at once
	wire wr_en     = reg_hit(wr_in, addr_in, `ADDR_TX_ENABLE_CTRL);
	wire wr_byte   = reg_hit(wr_in, addr_in, `ADDR_TX_BYTE_BUFFER);
	wire wr_timing = reg_hit(wr_in, addr_in, `ADDR_TX_TIMING_CONTROL);
	wire wr_status = reg_hit(wr_in, addr_in, `ADDR_TX_IRQ_STATUS);
	wire wr_mask   = reg_hit(wr_in, addr_in, `ADDR_TX_IRQ_MASK);
	// a write of zero to the enable aborts a frame in the cycle it lands
	wire stop_req  = wr_en && !wdata_in[`BIT_TX_ENABLE];

	// the ack slot is judged on the very last tick of its period
	wire slot_end = tick_at(fs_tick, tick_cnt_q, data_prd);
	wire done_ev  = (state_q == ST_ACK) && slot_end && !ack_bad;
	wire err_ev   = (state_q == ST_ACK) && slot_end && ack_bad;
	wire irq_ev   = done_ev | err_ev;

	// a new event wins over a write-one clear in the same cycle
	wire [`IRQ_WIDTH-1:0] status_clr = wr_status ? wdata_in[`IRQ_WIDTH-1:0]
	                                             : {`IRQ_WIDTH{1'b0}};
	wire [`IRQ_WIDTH-1:0] status_set = {err_ev, done_ev};

	// open drain: the pin value stays low and only the enable moves
	assign cec_out    = 1'b0;
	assign cec_oe_out = line_low_q;
	assign irq_out    = |(irq_status_q & irq_mask_q);

	// two flops ahead of anything that reads the shared line; idle level is high
	always @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			cec_sync1_q <= 1'b1;
			cec_sync2_q <= 1'b1;
		end else begin
			cec_sync1_q <= cec_in;
			cec_sync2_q <= cec_sync1_q;
		end
	end

	// the fs divider runs free, so a frame starts anywhere within one fs period
	always @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			fs_div_q <= 16'h0000;
		end else begin
			fs_div_q <= fs_tick ? 16'h0000 : fs_div_q + 16'h0001;
		end
	end

	// registers
	always @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			tx_enable_q  <= 1'b0;
			tx_byte_q    <= 9'h000;
			timing_q     <= 32'h00000000;
			irq_status_q <= {`IRQ_WIDTH{1'b0}};
			irq_mask_q   <= {`IRQ_WIDTH{1'b0}};
		end else begin
			// the self-clear beats a software write landing in the same cycle
			if (irq_ev)
				tx_enable_q <= 1'b0;
			else if (wr_en)
				tx_enable_q <= wdata_in[`BIT_TX_ENABLE];
			if (wr_byte)
				tx_byte_q <= wdata_in[8:0];
			if (wr_timing)
				timing_q <= wdata_in & `TIMING_WRITE_MASK;
			if (wr_mask)
				irq_mask_q <= wdata_in[`IRQ_WIDTH-1:0];
			irq_status_q <= (irq_status_q & ~status_clr) | status_set;
		end
	end

	// read data, one cycle after the strobe; enable bit is write only
	always @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			rdata_out <= 32'h00000000;
		end else if (rd_in) begin
			case (addr_in)
			`ADDR_TX_ENABLE_CTRL:    rdata_out <= {30'h0, tx_in_progress_q, 1'b0};
			`ADDR_TX_BYTE_BUFFER:    rdata_out <= {23'h0, tx_byte_q};
			`ADDR_TX_TIMING_CONTROL: rdata_out <= timing_q;
			`ADDR_TX_IRQ_STATUS:     rdata_out <= {30'h0, irq_status_q};
			`ADDR_TX_IRQ_MASK:       rdata_out <= {30'h0, irq_mask_q};
			default:                 rdata_out <= 32'h00000000;
			endcase
		end else begin
			rdata_out <= 32'h00000000;
		end
	end

	// transmit sequencer, stepped once per fs period except the idle step and aborts
	always @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			state_q          <= ST_IDLE;
			tick_cnt_q       <= 8'h00;
			bit_idx_q        <= 4'h0;
			free_cnt_q       <= 5'h00;
			line_low_q       <= 1'b0;
			tx_in_progress_q <= 1'b0;
		end else if (!tx_enable_q || stop_req) begin
			// disabling aborts at once and releases the line
			state_q          <= ST_IDLE;
			line_low_q       <= 1'b0;
			tx_in_progress_q <= 1'b0;
		end else begin
			case (state_q)
			ST_IDLE: begin
				state_q    <= ST_FREE;
				tick_cnt_q <= 8'h00;
				free_cnt_q <= 5'h00;
			end
			// a bus-free slot is one data period of high line
			ST_FREE: if (fs_tick) begin
				if (!cec_sync2_q) begin
					// any low activity restarts the idle window
					tick_cnt_q <= 8'h00;
					free_cnt_q <= 5'h00;
				end else if (tick_cnt_q == data_prd - 8'd1) begin
					tick_cnt_q <= 8'h00;
					if (free_cnt_q == {1'b0, bus_free_cycles}) begin
						state_q          <= ST_START;
						line_low_q       <= 1'b1;
						tx_in_progress_q <= 1'b1;
					end else begin
						free_cnt_q <= free_cnt_q + 5'h01;
					end
				end else begin
					tick_cnt_q <= tick_cnt_q + 8'h01;
				end
			end
			ST_START: if (fs_tick) begin
				if (tick_cnt_q == start_rise - 8'd1)
					line_low_q <= 1'b0;
				if (tick_cnt_q == start_prd - 8'd1) begin
					tick_cnt_q <= 8'h00;
					bit_idx_q  <= 4'h0;
					state_q    <= ST_DATA;
					line_low_q <= 1'b1;
				end else begin
					tick_cnt_q <= tick_cnt_q + 8'h01;
				end
			end
			ST_DATA: if (fs_tick) begin
				if (tick_cnt_q == data_rise - 8'd1)
					line_low_q <= 1'b0;
				if (tick_cnt_q == data_prd - 8'd1) begin
					tick_cnt_q <= 8'h00;
					bit_idx_q  <= bit_idx_q + 4'h1;
					line_low_q <= 1'b1;
					if (bit_idx_q == EOM_IDX)
						state_q <= ST_ACK;
				end else begin
					tick_cnt_q <= tick_cnt_q + 8'h01;
				end
			end
			// released after the rise; a follower may then hold the line low
			ST_ACK: if (fs_tick) begin
				if (tick_cnt_q == data_rise - 8'd1)
					line_low_q <= 1'b0;
				if (irq_ev) begin
					state_q          <= ST_IDLE;
					line_low_q       <= 1'b0;
					tx_in_progress_q <= 1'b0;
				end else begin
					tick_cnt_q <= tick_cnt_q + 8'h01;
				end
			end
			default: begin
				state_q    <= ST_IDLE;
				line_low_q <= 1'b0;
			end
			endcase
		end
	end

endmodule

`default_nettype wire

// *** verification/cec_tx_props.sv ***
`timescale 1ns/1ns
`default_nettype none
module cec_tx_props #(parameter int FS_DIV = 4) (
	input wire logic        core_clk_in,
	input wire logic        reset_in,
	input wire logic [7:0]  addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic        wr_in,
	input wire logic        rd_in,
	input wire logic [31:0] rdata_out,
	input wire logic        cec_in,
	input wire logic        cec_out,
	input wire logic        cec_oe_out,
	input wire logic        irq_out
);
	localparam int MAXLOW = 121 * FS_DIV + 4;
	logic [1:0] mask_q;
	// shadow of the mask so the interrupt level can be judged from the ports
	always @(posedge core_clk_in or posedge reset_in)
		if (reset_in) mask_q <= 2'h0;
		else if (wr_in && addr_in == 8'h10) mask_q <= wdata_in[1:0];
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (reset_in);
	read_idle_a: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
		else $error("read data outside read");
	en_read_a: assert property (rd_in && addr_in == 8'h00 |=> !rdata_out[0])
		else $error("enable bit readable");
	en_rsv_a: assert property (rd_in && addr_in == 8'h00 |=> rdata_out[31:2] == 30'h0)
		else $error("enable reserved bits set");
	byte_rsv_a: assert property (rd_in && addr_in == 8'h04 |=> rdata_out[31:9] == 23'h0)
		else $error("byte reserved bits set");
	tim_rsv_a: assert property (rd_in && addr_in == 8'h08 |=> (rdata_out & 32'hFF8880E0) == 32'h0)
		else $error("timing reserved bits set");
	busy_rd_a: assert property (rd_in && addr_in == 8'h00 && cec_oe_out |=> rdata_out[1])
		else $error("busy low while driving");
	low_min_a: assert property ($rose(cec_oe_out) |=> cec_oe_out [*8])
		else $error("low pulse too short");
	low_max_a: assert property ($rose(cec_oe_out) |-> ##[1:MAXLOW] !cec_oe_out)
		else $error("low pulse too long");
	abort_a: assert property (wr_in && addr_in == 8'h00 && !wdata_in[0] |-> ##2 !cec_oe_out)
		else $error("line held after disable");
	irq_lvl_a: assert property (rd_in && addr_in == 8'h0C |=> irq_out == |(rdata_out[1:0] & mask_q))
		else $error("interrupt level wrong");
	drive_a: assert property (cec_out == 1'b0)
		else $error("line driven high");
	tx_c: cover property ($rose(cec_oe_out));
	irq_c: cover property ($rose(irq_out));
	abort_c: cover property (wr_in && addr_in == 8'h00 && !wdata_in[0] && cec_oe_out);
endmodule
bind cec_transmit_control cec_tx_props #(.FS_DIV(FS_DIV)) props (.core_clk_in(core_clk_in),
	.reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
	.rdata_out(rdata_out), .cec_in(cec_in), .cec_out(cec_out), .cec_oe_out(cec_oe_out),
	.irq_out(irq_out));
`default_nettype wire

// *** verification/cec_line_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module cec_line_model #(parameter int HOLD = 330) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic pull_in,
	input wire logic ack_en_in,
	output var logic line_out
);
	int   n_q;
	int   hold_q;
	logic pull_q;
	// eleventh low pulse of a frame is the acknowledge slot; held past its end
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			n_q <= 0;
			hold_q <= 0;
			pull_q <= 1'b0;
		end else begin
			pull_q <= pull_in;
			if (hold_q > 0) hold_q <= hold_q - 1;
			if (pull_in && !pull_q) begin
				n_q <= (n_q == 10) ? 0 : n_q + 1;
				if (n_q == 10 && ack_en_in) hold_q <= HOLD;
			end
		end
	end
	// pull-up: high unless someone pulls
	assign line_out = !(pull_in || hold_q > 0);
endmodule
`default_nettype wire

// *** verification/cec_transmit_control_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module cec_transmit_control_tb;
	localparam int F = 4;
	logic        core_clk_in = 1'b0, reset_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
	logic        ack_en = 1'b0, rd_d = 1'b0, oe_d = 1'b0;
	logic [7:0]  addr_in = 8'h00;
	logic [31:0] wdata_in = 32'h0;
	logic [8:0]  b;
	wire logic [31:0] rdata_out;
	wire logic   line, oe, irq;
	int          error_cnt = 0, n_checks = 0, t = 0, tf = -5000, seed = 66;
	int          f, r, p, d, q, fr, n, x;
	int          lq[$], pq[$];
	logic [31:0] rq[$];
	always #5 core_clk_in = ~core_clk_in;
	cec_transmit_control #(.FS_DIV(F)) DUT (.core_clk_in(core_clk_in), .reset_in(reset_in),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.rdata_out(rdata_out), .cec_in(line), .cec_out(), .cec_oe_out(oe), .irq_out(irq));
	cec_line_model mdl (.clk_in(core_clk_in), .rst_in(reset_in), .pull_in(oe),
		.ack_en_in(ack_en), .line_out(line));
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk_in);
		wr_in <= w;
		rd_in <= !w;
		addr_in <= a;
		wdata_in <= v;
		if (!w) rq.push_back(v);
		@(posedge core_clk_in);
		wr_in <= 1'b0;
		rd_in <= 1'b0;
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// watches read data and measures each low pulse of the DUT drive enable and each bit period before the ack slot
	always @(posedge core_clk_in) begin
		t <= t + 1;
		rd_d <= rd_in;
		oe_d <= oe;
		if (rd_d) cmp(rdata_out, rq.pop_front());
		if (!oe && oe_d && lq.size() > 0) cmp(t - tf, lq.pop_front());
		if (oe && !oe_d) begin
			if (t - tf < 1000 && pq.size() > 0) cmp(t - tf, pq.pop_front());
			tf <= t;
		end
		if (t > 40000) begin
			error_cnt++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (6) @(posedge core_clk_in);
		reset_in <= 1'b0;
		for (x = 0; x < 24; x += 4) acc(0, x[7:0], 32'h0);
		acc(1, 8'h04, 32'hFFFFFFFF);
		acc(0, 8'h04, 32'h1FF);
		acc(1, 8'h08, 32'hFFFFFFFF);
		acc(0, 8'h08, 32'h00777F1F);
		acc(1, 8'h00, 32'h2);
		acc(0, 8'h00, 32'h0);
		acc(1, 8'h14, 32'hFFFFFFFF);
		acc(0, 8'h10, 32'h0);
		acc(1, 8'h10, 32'h3);
		$display("register test done");
		// frames: acknowledged, broadcast unanswered, direct unanswered
		for (f = 0; f < 3; f++) begin
			r = {$random(seed)} % 8;
			p = {$random(seed)} % 8;
			d = {$random(seed)} % 4;
			q = {$random(seed)} % 16;
			fr = {$random(seed)} % 2;
			b = 9'($random(seed));
			ack_en <= (f == 0);
			acc(1, 8'h04, {23'h0, b});
			acc(1, 8'h08, {9'h0, r[2:0], 1'b0, p[2:0], 1'b0, d[2:0], q[3:0], 3'h0, f == 1, fr[3:0]});
			lq.push_back((121 - r) * F);
			pq.push_back((147 - p) * F);
			for (n = 0; n < 9; n++) begin
				lq.push_back(((b[n < 8 ? 7 - n : 8] ? 20 : 49) - d) * F);
				pq.push_back((79 - q) * F);
			end
			lq.push_back((20 - d) * F);
			acc(1, 8'h00, 32'h1);
			x = (fr + 1) * (79 - q) * F;
			for (n = 0; oe !== 1'b1 && n < 9000; n++) @(posedge core_clk_in);
			cmp(n >= x - F && n <= x + 4 * F, 1);
			for (n = 0; irq !== 1'b1 && n < 5000; n++) @(posedge core_clk_in);
			acc(0, 8'h0C, f == 2 ? 32'h2 : 32'h1);
			acc(0, 8'h00, 32'h0);
			acc(1, 8'h10, 32'h0);
			@(negedge core_clk_in);
			cmp(irq, 0);
			acc(1, 8'h10, 32'h3);
			acc(1, 8'h0C, 32'h3);
			@(negedge core_clk_in);
			cmp(irq, 0);
			repeat (1000) @(posedge core_clk_in);
			$display("frame %0d done", f);
		end
		acc(1, 8'h00, 32'h1);
		for (n = 0; oe !== 1'b1 && n < 9000; n++) @(posedge core_clk_in);
		repeat (20) @(posedge core_clk_in);
		acc(0, 8'h00, 32'h2);
		acc(1, 8'h00, 32'h2);
		acc(0, 8'h00, 32'h0);
		cmp(oe, 0);
		acc(0, 8'h0C, 32'h0);
		$display("abort test done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
